// ### logic/tws_slave.sv
// Two-wire serial memory slave: bus conditions, byte engine and write protect.
`timescale 1ns/100ps
module tws_slave #(
  parameter int FILT = tws_pkg::FILT_CYC
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  // Serial clock from the master, input only
  input wire logic scl_in,
  // Serial data line as seen on the wire
  input wire logic sda_in,
  // Level driven when enabled, always low
  output logic sda_out,
  // High while the slave pulls the data line
  output logic sda_oe_out,
  // Write protect pin, high protects upper half
  input wire logic wp_in
);
  // Filtered, synchronised bus lines
  logic scl_f;
  logic sda_f;
  // Registered engine state and its next value
  tws_pkg::tws_core_t r;
  tws_pkg::tws_core_t n;
  // Bus events of this cycle
  logic rise_c;
  logic fall_c;
  logic start_c;
  logic stop_c;
  // Received byte complete on the falling edge
  logic dec_c;
  // Protected target for a data byte
  logic prot_c;
  // Load the shifter with the next read byte
  logic load_c;
  // Write request to the array
  tws_pkg::tws_wr_t wr_c;
  // Array read data for the current address
  logic [7:0] rdata;

  // Clock line filter; the clock is only ever sampled
  tws_filt #(.FILT(FILT)) u_scl_filt (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .line_in(scl_in),
    .line_out(scl_f)
  );

  // Data line filter, same delay as the clock so ordering holds
  tws_filt #(.FILT(FILT)) u_sda_filt (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .line_in(sda_in),
    .line_out(sda_f)
  );

  // Storage array, read address follows the address latch
  tws_mem u_mem (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .wr_in(wr_c),
    .raddr_in(r.addr),
    .rdata_out(rdata)
  );

  // Edge and condition decode on the filtered lines
  always_comb begin
    rise_c = !r.scl_p && scl_f;
    fall_c = r.scl_p && !scl_f;
    // Data falls while the clock stays high
    start_c = r.scl_p && scl_f && r.sda_p && !sda_f;
    // Data rises while the clock stays high
    stop_c = r.scl_p && scl_f && !r.sda_p && sda_f;
    dec_c = (r.st == tws_pkg::ST_RX) && fall_c && (r.bits == tws_pkg::BYTE_BITS);
    // Upper half when the bank select bit is set and the pin protects
    prot_c = r.wp_s && r.addr[tws_pkg::BANK_BIT];
  end

  // Next state of the engine
  always_comb begin
    n = r;
    load_c = 1'b0;
    wr_c = '0;
    // Edge history and the two-flop write protect synchroniser
    n.scl_p = scl_f;
    n.sda_p = sda_f;
    n.wp_m = wp_in;
    n.wp_s = r.wp_m;
    // The line is never driven high, only enabled low
    n.dout = 1'b0;
    if (start_c) begin
      // Any start restarts at the slave byte
      n.st = tws_pkg::ST_RX;
      n.kind = tws_pkg::K_SLV;
      n.bits = '0;
      n.oe = 1'b0;
    end else if (stop_c) begin
      // Stop drops whatever was going on
      n.st = tws_pkg::ST_IDLE;
      n.oe = 1'b0;
    end else begin
      case (r.st)
        // Nothing is heard until a start
        tws_pkg::ST_IDLE: begin
          n.oe = 1'b0;
        end
        // Shift in a byte, sampling on the clock rise
        tws_pkg::ST_RX: begin
          if (rise_c) begin
            n.sh = {r.sh[6:0], sda_f};
            n.bits = r.bits + tws_pkg::BIT_ONE;
          end else if (dec_c) begin
            // Ninth clock: pull low unless refused below
            n.bits = '0;
            n.st = tws_pkg::ST_ACK;
            n.oe = 1'b1;
            case (r.kind)
              tws_pkg::K_SLV: begin
                if (r.sh[7:4] == tws_pkg::DEV_TYPE) begin
                  // Page bits feed the top of the latch
                  n.page = r.sh[3:1];
                  n.rw = r.sh[0];
                  if (r.sh[0]) begin
                    n.addr[10:8] = r.sh[3:1];
                  end
                end else begin
                  // Not addressed: stay off the bus
                  n.st = tws_pkg::ST_IDLE;
                  n.oe = 1'b0;
                end
              end
              tws_pkg::K_WORD: begin
                // Word address is always acknowledged
                n.addr = {r.page, r.sh};
              end
              default: begin
                if (prot_c) begin
                  // Protected: no acknowledge, no store, no step
                  n.st = tws_pkg::ST_IDLE;
                  n.oe = 1'b0;
                end else begin
                  // Store and step before the acknowledge
                  wr_c.we = 1'b1;
                  wr_c.addr = r.addr;
                  wr_c.data = r.sh;
                  n.addr = r.addr + tws_pkg::ADDR_INC;
                end
              end
            endcase
          end
        end
        // Hold the acknowledge until the ninth clock falls
        tws_pkg::ST_ACK: begin
          if (fall_c) begin
            n.oe = 1'b0;
            if (r.rw) begin
              // Read: first data byte goes straight out
              load_c = 1'b1;
            end else begin
              // Write: next byte is an address or data
              n.st = tws_pkg::ST_RX;
              n.kind = (r.kind == tws_pkg::K_SLV) ? tws_pkg::K_WORD : tws_pkg::K_DATA;
            end
          end
        end
        // Send a byte, changing the line after each fall
        tws_pkg::ST_TX: begin
          if (rise_c) begin
            n.bits = r.bits + tws_pkg::BIT_ONE;
          end else if (fall_c) begin
            if (r.bits == tws_pkg::BYTE_BITS) begin
              // Release for the master's acknowledge
              n.oe = 1'b0;
              n.st = tws_pkg::ST_MACK;
            end else begin
              n.sh = {r.sh[6:0], 1'b0};
              n.oe = !r.sh[6];
            end
          end
        end
        // Master acknowledge after a read byte
        tws_pkg::ST_MACK: begin
          if (rise_c) begin
            n.mack = !sda_f;
          end else if (fall_c) begin
            if (r.mack) begin
              load_c = 1'b1;
            end else begin
              // No acknowledge ends the read
              n.st = tws_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          n.st = tws_pkg::ST_IDLE;
          n.oe = 1'b0;
        end
      endcase
    end
    // Load next read byte, drive its top bit and step the latch
    if (load_c) begin
      n.st = tws_pkg::ST_TX;
      n.bits = '0;
      n.sh = rdata;
      n.oe = !rdata[7];
      n.addr = r.addr + tws_pkg::ADDR_INC;
    end
  end

  // Single state register; reset leaves the bus released
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= tws_pkg::CORE_RST;
    end else begin
      r <= n;
    end
  end

  // Both pins come straight from the state register
  assign sda_out = r.dout;
  assign sda_oe_out = r.oe;

  // Checks on the engine
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  // The pin never carries a high level
  property p_low_only;
    !sda_out;
  endproperty
  a_low_only: assert property (p_low_only) else $error("data line driven high");

  // Start restarts at the slave byte with the line released
  property p_start;
    start_c |=> r.st == tws_pkg::ST_RX && r.kind == tws_pkg::K_SLV && r.bits == '0 && !sda_oe_out;
  endproperty
  a_start: assert property (p_start) else $error("start did not restart");

  // Stop goes idle and stays idle without a start
  property p_stop;
    stop_c ##1 !start_c |-> r.st == tws_pkg::ST_IDLE ##1 r.st == tws_pkg::ST_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not idle");

  // Shifter takes a bit only on a clock rise
  property p_sample;
    r.st == tws_pkg::ST_RX && $changed(r.sh) |-> $past(rise_c);
  endproperty
  a_sample: assert property (p_sample) else $error("bit taken off the rise");

  // Transmit line changes only after the clock fell
  property p_tx_change;
    r.st == tws_pkg::ST_TX && $changed(sda_oe_out) |-> !$past(scl_f);
  endproperty
  a_tx_change: assert property (p_tx_change) else $error("output moved clock high");

  // Word address byte is acknowledged in the cycle after it completes
  property p_word_ack;
    dec_c && r.kind == tws_pkg::K_WORD |=> sda_oe_out && r.st == tws_pkg::ST_ACK;
  endproperty
  a_word_ack: assert property (p_word_ack) else $error("word address not acked");

  // Protected data byte: no store, no acknowledge, latch kept
  property p_protect;
    dec_c && r.kind == tws_pkg::K_DATA && prot_c
      |-> !wr_c.we ##1 !sda_oe_out && $stable(r.addr) && r.st == tws_pkg::ST_IDLE;
  endproperty
  a_protect: assert property (p_protect) else $error("protected byte handled");

  // Lower half is written and stepped whatever the pin says
  property p_lower;
    dec_c && r.kind == tws_pkg::K_DATA && !r.addr[tws_pkg::BANK_BIT]
      |-> wr_c.we ##1 r.addr == 11'($past(r.addr) + tws_pkg::ADDR_INC) && sda_oe_out;
  endproperty
  a_lower: assert property (p_lower) else $error("lower half write lost");

  // No write ever lands in the protected half
  property p_no_prot_wr;
    wr_c.we |-> !(r.wp_s && wr_c.addr[tws_pkg::BANK_BIT]);
  endproperty
  a_no_prot_wr: assert property (p_no_prot_wr) else $error("protected write");

  // Master not acknowledging ends the read
  property p_nack;
    r.st == tws_pkg::ST_MACK && fall_c && !r.mack |=> r.st == tws_pkg::ST_IDLE && !sda_oe_out;
  endproperty
  a_nack: assert property (p_nack) else $error("read went on after nack");

  // Wrong device type keeps the slave off the bus
  property p_bad_id;
    dec_c && r.kind == tws_pkg::K_SLV && r.sh[7:4] != tws_pkg::DEV_TYPE
      |=> r.st == tws_pkg::ST_IDLE && !sda_oe_out;
  endproperty
  a_bad_id: assert property (p_bad_id) else $error("foreign address acked");

  // Main scenarios
  c_write: cover property (wr_c.we);
  c_read_more: cover property (r.st == tws_pkg::ST_MACK && fall_c && r.mack);
  c_protect: cover property (dec_c && r.kind == tws_pkg::K_DATA && prot_c);
  c_restart: cover property (start_c && r.st != tws_pkg::ST_IDLE);
endmodule : tws_slave

// ### logic/tws_pkg.sv
// Constants, state types and carriers for the two-wire serial memory slave.
package tws_pkg;
  // Clock period and glitch width, in ns
  localparam int CLK_NS = 8;
  localparam int SPIKE_NS = 50;
  // Longest glitch spans this many samples, rounded up
  localparam int FILT_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
  // Memory geometry: 2048 bytes, 11-bit address
  localparam int MEM_AW = 11;
  localparam int MEM_DW = 8;
  // Address bit that selects the upper half
  localparam int BANK_BIT = 10;
  // Device type field of the slave byte
  localparam logic [3:0] DEV_TYPE = 4'hA;
  // Bits in one byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [MEM_AW-1:0] ADDR_INC = 11'h001;
  // Idle level of a pulled-up bus line
  localparam logic LINE_IDLE = 1'h1;

  // Transfer state
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} tws_st_t;
  // Which byte is being received
  typedef enum logic [1:0] {K_SLV, K_WORD, K_DATA} tws_kind_t;

  // Write port carrier toward the array
  typedef struct packed {
    logic we;
    logic [MEM_AW-1:0] addr;
    logic [MEM_DW-1:0] data;
  } tws_wr_t;

  // Whole state of the protocol engine
  typedef struct packed {
    tws_st_t st;
    tws_kind_t kind;
    logic [3:0] bits;
    logic [7:0] sh;
    logic rw;
    logic [2:0] page;
    logic [MEM_AW-1:0] addr;
    logic oe;
    logic dout;
    logic mack;
    logic scl_p;
    logic sda_p;
    logic wp_m;
    logic wp_s;
  } tws_core_t;

  // Reset image: bus released; edge history starts at the idle high level
  // so the first cycle after reset never shows a false clock rise
  localparam tws_core_t CORE_RST = '{
    st: ST_IDLE, kind: K_SLV, bits: 4'h0, sh: 8'h00, rw: 1'h0, page: 3'h0,
    addr: '0, oe: 1'h0, dout: 1'h0, mack: 1'h0,
    scl_p: LINE_IDLE, sda_p: LINE_IDLE, wp_m: 1'h0, wp_s: 1'h0
  };
endpackage : tws_pkg

// ### logic/tws_filt.sv
// Two-flop synchroniser plus spike filter for one bus line.
`timescale 1ns/100ps
module tws_filt #(
  parameter int FILT = tws_pkg::FILT_CYC
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic line_in,
  output logic line_out
);
  // Counter wide enough for the filter length
  localparam int CW = $clog2(FILT + 1);
  typedef struct packed {
    logic s1;
    logic s2;
    logic [CW-1:0] cnt;
    logic q;
  } tws_filt_st_t;
  localparam tws_filt_st_t FILT_RST = '{s1: tws_pkg::LINE_IDLE, s2: tws_pkg::LINE_IDLE,
                                         cnt: '0, q: tws_pkg::LINE_IDLE};
  localparam logic [CW-1:0] CNT_LAST = CW'(FILT - 1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  tws_filt_st_t r, n;

  // New level must hold for FILT samples before it is taken
  always_comb begin
    n = r;
    n.s1 = line_in;
    n.s2 = r.s1;
    if (r.s2 == r.q) begin
      n.cnt = '0;
    end else if (r.cnt == CNT_LAST) begin
      n.q = r.s2;
      n.cnt = '0;
    end else begin
      n.cnt = r.cnt + CNT_ONE;
    end
  end

  // State register, bus lines idle high
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= FILT_RST;
    end else begin
      r <= n;
    end
  end

  assign line_out = r.q;

  // Output only moves after a full run of the other level
  property p_filt_run;
    @(posedge clk_in) disable iff (!rstn_in)
    $changed(r.q) |-> $past(r.cnt) == CNT_LAST && $past(r.s2) != $past(r.q);
  endproperty
  a_filt_run: assert property (p_filt_run) else $error("filter passed short pulse");
endmodule : tws_filt

// ### logic/tws_mem.sv
// Byte array behind the slave: one write port, one registered read port.
`timescale 1ns/100ps
module tws_mem #(
  parameter int AW = tws_pkg::MEM_AW,
  parameter int DW = tws_pkg::MEM_DW
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire tws_pkg::tws_wr_t wr_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [DW-1:0] rdata_out
);
  // Storage; contents are not cleared by reset
  logic [DW-1:0] mem_r [0:(1<<AW)-1];
  logic [DW-1:0] rdata_r;

  // Write port
  always_ff @(posedge clk_in) begin
    if (wr_in.we) begin
      mem_r[wr_in.addr[AW-1:0]] <= wr_in.data[DW-1:0];
    end
  end

  // Read port, one cycle of latency
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem_r[raddr_in];
    end
  end

  assign rdata_out = rdata_r;
endmodule : tws_mem

// ### dv/tws_master_model.sv
// Bus master model: open-drain clock and data, bit and byte tasks.
`timescale 1ns/100ps
module tws_master_model #(
  // Sixteen system clocks per bit: the nearest whole count to a 125 ns bit
  parameter int QTR_CYC = 4
) (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // Width of a spike added to each bit; zero disables it
  real spike_ns = 0.0;

  // Both lines released: clock stands high between frames
  initial begin
    scl_out = 1'h1;
    sda_out = 1'h1;
  end

  // Quarter bit; lines move on falling edges except at the end of a spike, never on the sampling edge
  task automatic qtr();
    repeat (QTR_CYC) @(negedge clk_in);
  endtask : qtr

  // Start, also used as repeated start from clock low
  task automatic start_cond();
    sda_out = 1'h1;
    qtr();
    scl_out = 1'h1;
    qtr();
    sda_out = 1'h0;
    qtr();
    scl_out = 1'h0;
    qtr();
  endtask : start_cond

  // Stop, then the bus stays idle high
  task automatic stop_cond();
    sda_out = 1'h0;
    qtr();
    scl_out = 1'h1;
    qtr();
    sda_out = 1'h1;
    qtr();
    qtr();
  endtask : stop_cond

  // One clock period; data is set while the clock is low and moves while high only in a spike
  task automatic put_bit(input logic b, output logic seen);
    sda_out = b;
    if (spike_ns > 0.0) begin
      // Short false clock pulse in the low phase, one sample wide
      scl_out = 1'h1;
      #(spike_ns);
      scl_out = 1'h0;
    end
    qtr();
    scl_out = 1'h1;
    qtr();
    seen = sda_in;
    if (spike_ns > 0.0) begin
      // Short data flip while the clock is high
      sda_out = ~b;
      #(spike_ns);
      sda_out = b;
    end
    qtr();
    scl_out = 1'h0;
    qtr();
  endtask : put_bit

  // Byte out, MSB first, then the data line is released for the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], s);
    end
    put_bit(1'h1, s);
    ack = ~s;
  endtask : send_byte

  // Byte in; acknowledge low asks for more, high ends the read
  task automatic get_byte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'h1, b[i]);
    end
    put_bit(~more, s);
  endtask : get_byte
endmodule : tws_master_model

// ### dv/tws_slave_test.sv
// Self-checking bench for the two-wire memory slave.
`timescale 1ns/100ps
module tws_slave_test;
  // One plain write then read-back case
  typedef struct packed {
    logic [10:0] addr;
    logic [7:0] data;
  } tws_row_t;

  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic wp = 1'h0;
  logic scl;
  logic m_sda;
  logic sda_o;
  logic sda_oe;
  logic sda_wire;
  logic k;
  logic [7:0] d;
  int fail_count = 0;
  int samples_checked = 0;
  tws_row_t rows [7] = '{'{11'h000, 8'h5A}, '{11'h3FF, 8'hC3}, '{11'h400, 8'h81},
    '{11'h7FE, 8'h3C}, '{11'h123, 8'hFF}, '{11'h2AA, 8'h00}, '{11'h010, 8'h42}};

  // 125 MHz system clock
  always #4 clk = ~clk;

  // Pull-up wire: anyone driving low wins
  assign sda_wire = (sda_oe ? sda_o : 1'h1) & m_sda;

  tws_master_model m (.clk_in(clk), .sda_in(sda_wire), .scl_out(scl), .sda_out(m_sda));

  // Small filter keeps the answer inside the 64 ns clock half
  tws_slave #(.FILT(2)) dut (.clk_in(clk), .rstn_in(rstn), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .wp_in(wp));

  // The slave may only pull low, never drive high
  always @(negedge clk) begin
    if (sda_oe === 1'h1 && sda_o !== 1'h0) begin
      fail_count++;
      $display("wrong value at %0t: data line driven high", $time);
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Start, slave byte and word byte of a write
  task automatic head(input logic [10:0] a);
    m.start_cond();
    m.send_byte({tws_pkg::DEV_TYPE, a[10:8], 1'h0}, k);
    check(8'(k), 8'h01, "slave ack");
    m.send_byte(a[7:0], k);
    check(8'(k), 8'h01, "word ack");
  endtask : head

  // Repeated start into a read of the page
  task automatic rd_head(input logic [2:0] pg);
    m.start_cond();
    m.send_byte({tws_pkg::DEV_TYPE, pg, 1'h1}, k);
    check(8'(k), 8'h01, "read ack");
  endtask : rd_head

  task automatic wr1(input logic [10:0] a, input logic [7:0] v, output logic ack);
    head(a);
    m.send_byte(v, ack);
    m.stop_cond();
  endtask : wr1

  task automatic rd1(input logic [10:0] a, input logic [7:0] exp);
    head(a);
    rd_head(a[10:8]);
    m.get_byte(1'h0, d);
    check(d, exp, "read data");
    m.stop_cond();
  endtask : rd1

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // Watchdog: the tests need roughly 114 us
  initial begin
    #600000;
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    repeat (6) @(negedge clk);
    check(8'(sda_oe), 8'h00, "oe in reset");
    repeat (6) @(negedge clk);
    rstn = 1'h1;
    repeat (20) @(negedge clk);
    check(8'(sda_oe), 8'h00, "oe after reset");
    end_test("reset");
    // Plain writes then read-back, write protect low
    foreach (rows[i]) begin
      wr1(rows[i].addr, rows[i].data, k);
      check(8'(k), 8'h01, "data ack");
      rd1(rows[i].addr, rows[i].data);
    end
    end_test("rows");
    // Protected upper half: refused, no step, lower half still writable
    @(negedge clk) wp = 1'h1;
    repeat (4) @(negedge clk);
    wr1(11'h400, 8'h77, k);
    check(8'(k), 8'h00, "protected ack");
    m.start_cond();
    m.send_byte({tws_pkg::DEV_TYPE, 3'h4, 1'h1}, k);
    m.get_byte(1'h0, d);
    check(d, 8'h81, "no step");
    m.stop_cond();
    wr1(11'h100, 8'h66, k);
    check(8'(k), 8'h01, "lower ack");
    rd1(11'h100, 8'h66);
    @(negedge clk) wp = 1'h0;
    end_test("protect");
    // Wrap from the last byte, sequential read, nack then idle
    head(11'h7FF);
    m.send_byte(8'hE1, k);
    m.send_byte(8'h1E, k);
    m.stop_cond();
    head(11'h7FF);
    rd_head(3'h7);
    m.get_byte(1'h1, d);
    check(d, 8'hE1, "last byte");
    m.get_byte(1'h0, d);
    check(d, 8'h1E, "wrapped byte");
    m.get_byte(1'h0, d);
    check(d, 8'hFF, "after nack");
    m.stop_cond();
    end_test("wrap");
    // Foreign device type
    m.start_cond();
    m.send_byte(8'h50, k);
    check(8'(k), 8'h00, "foreign ack");
    m.stop_cond();
    end_test("type");
    // Start in mid byte aborts and restarts at the slave byte
    head(11'h010);
    repeat (4) m.put_bit(1'h1, k);
    rd_head(3'h0);
    m.get_byte(1'h0, d);
    check(d, 8'h42, "after restart");
    m.stop_cond();
    // Stop in mid byte aborts; traffic without start is ignored
    head(11'h010);
    repeat (5) m.put_bit(1'h0, k);
    m.stop_cond();
    m.send_byte({tws_pkg::DEV_TYPE, 3'h0, 1'h0}, k);
    check(8'(k), 8'h00, "no start ack");
    m.stop_cond();
    rd1(11'h010, 8'h42);
    end_test("abort");
    // One-sample spikes on both lines are not edges
    m.spike_ns = 5.0;
    wr1(11'h020, 8'hA5, k);
    m.spike_ns = 0.0;
    check(8'(k), 8'h01, "spike ack");
    rd1(11'h020, 8'hA5);
    end_test("spike");
    final_report();
  end
endmodule : tws_slave_test
